/* fsms_pkg.sv */
// Constants, register map and enumerations of the feedback sampling core.
// Assumes a 250 MHz core clock and feedback codes of 1 mV per step.
package fsms_pkg;
    localparam int                 CLK_MHZ        = 250;
    localparam int                 FIXED_HALF_US  = 9823;  // 9.823 ms
    localparam int                 FIXED_HALF_CYC = FIXED_HALF_US * CLK_MHZ;
    localparam int                 BURST_SW_US    = 50;
    localparam int                 BURST_SW_CYC   = BURST_SW_US * CLK_MHZ;
    localparam int                 SAMPLES_LOG2   = 6;     // 64 per half-cycle
    localparam logic [11:0]        LVL_BURST      = 12'h320;
    localparam logic [11:0]        LVL_ON         = 12'h4b0;
    localparam logic [11:0]        LVL_SW         = 12'h7d0;
    localparam logic [11:0]        LVL_REF        = 12'h97c;
    localparam int                 LP_SHIFT       = 3;
    localparam int                 NOTCH_FRAC     = 14;
    localparam logic signed [19:0] NOTCH_C2       = 20'sh0_7f62;
    localparam logic signed [19:0] NOTCH_ONE      = 20'sh0_4000;
    localparam logic [39:0]        MAP_INV        = 40'h00_0000_06d3;
    localparam int                 MAP_SHIFT      = 21;
    localparam int                 PFC_SHIFT      = 6;
    localparam int                 TON_SHIFT      = 4;
    localparam logic [4:0]         PULSE_MIN      = 5'h01;
    localparam logic [7:0]         ADDR_CTRL      = 8'h00;
    localparam logic [7:0]         ADDR_NOTCH     = 8'h04;
    localparam logic [7:0]         ADDR_BURST     = 8'h08;
    localparam logic [7:0]         ADDR_RAMP      = 8'h0c;
    localparam logic [7:0]         ADDR_PERIOD    = 8'h10;
    localparam logic [7:0]         ADDR_ONTIME    = 8'h14;
    localparam logic [7:0]         ADDR_STATUS    = 8'h18;
    localparam logic [7:0]         ADDR_MAP       = 8'h1c;

    typedef enum logic [1:0] {
        MODE_FV    = 2'b00,
        MODE_DCM   = 2'b01,
        MODE_BURST = 2'b10
    } fsms_mode_type;

    typedef enum logic [1:0] {
        BST_SLEEP = 2'b00,
        BST_WAKE  = 2'b01,
        BST_PULSE = 2'b10
    } fsms_burst_type;
endpackage : fsms_pkg

/* fsms_core.sv */
// Feedback sampling, filtering and operating mode selection of a flyback controller.
// Assumes pin inputs synchronous to pclk and an APB master on the register port.
// Notes on behaviour
// R01 - Sample feedback right after sense blanking; rate follows mode.
// R02 - With line sync, 64 even samples per synchronised half-cycle.
// R03 - Without sync in valley or discontinuous mode, 64 samples per 9.823 ms.
// R04 - No feedback sampling during burst sleep; pull-up is off there.
// R05 - Pull-up back on a wake-up count before pulsing and sampling.
// R06 - Burst pulsing samples on last synced period, else 9.823 ms.
// R07 - Notch filter after sync held the notch blanking count.
// R08 - Notch zeros at twice line frequency, pole radius from quality.
// R09 - Low-pass filter whenever notch condition is not met.
// R10 - Burst mode filters with low-pass only, only while pulsing.
// R11 - Mode and switching parameters come from the filtered level.
// R12 - On regulation entry, ramp a ceiling on the mapped level.
// R13 - Level at least 1.2 V and short period gives first-valley mode.
// R14 - First-valley mode turns on at the first valley.
// R15 - Discontinuous mode turns on later than the first valley.
// R16 - Enhanced PFC modulates mapped on-time by a gain.
// R17 - Below 0.8 V for the entry delay enters burst mode.
// R18 - Between 0.8 V and 1.2 V runs discontinuous mode with minimum on-time; code sets on-time to ton_min plus level x ton_gain / 16.
// R19 - At 1.2 V or more with long period runs discontinuous mode.
// R20 - Filtered level holds while burst sleep stops sampling.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module fsms_core
    import fsms_pkg::*;
#(
    parameter int FIXED_HALF_CYC_P = FIXED_HALF_CYC,
    parameter int BURST_SW_CYC_P   = BURST_SW_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [11:0]        feedback_sample,
    input  wire logic               blank_end,
    input  wire logic               line_sync,
    input  wire logic               half_cycle,
    input  wire logic               valley_pulse,
    input  wire logic [15:0]        first_valley_period,
    input  wire logic               burst_tick,
    input  wire logic signed [11:0] pfc_term,
    output logic                    sample_strobe,
    output logic                    feedback_pullup_en,
    output logic                    gate_drive_on,
    output logic      [1:0]         operating_mode,
    output logic      [15:0]        on_time,
    output logic      [15:0]        min_period,
    output logic      [4:0]         pulse_count,
    output logic      [11:0]        filtered_feedback_level,
    output logic      [11:0]        feedback_ceiling
);
    typedef struct packed {
        logic               ack;
        logic               err;
        logic [31:0]        rdata;
        logic               regulate_en;
        logic               pfc_en;
        logic [7:0]         notch_blank;
        logic [3:0]         q_shift;
        logic [15:0]        wake_cnt;
        logic [15:0]        burst_delay;
        logic [7:0]         ramp_step;
        logic [7:0]         pfc_gain;
        logic [15:0]        fast_period;
        logic [15:0]        ton_min;
        logic [7:0]         ton_gain;
        logic [21:0]        per_cnt;
        logic [21:0]        half_period;
        logic               sync_seen;
        logic               sync_at_burst;
        logic [7:0]         sync_age;
        logic [21:0]        fix_cnt;
        logic [21:0]        int_cnt;
        logic               armed;
        logic               strobe;
        logic [15:0]        lp;
        logic [11:0]        x1;
        logic [11:0]        x2;
        logic signed [19:0] y1;
        logic signed [19:0] y2;
        logic [11:0]        level;
        logic [11:0]        ceiling;
        logic               reg_prev;
        logic [23:0]        below_cnt;
        fsms_mode_type      mode;
        fsms_burst_type     bst;
        logic [15:0]        bst_cnt;
        logic [4:0]         pulses_left;
        logic [15:0]        sw_cnt;
        logic               valley_seen;
        logic               gate;
        logic [15:0]        on_time;
        logic [15:0]        min_period;
        logic [4:0]         pulse_count;
        logic [11:0]        burst_level;
    } fsms_state_type;

    fsms_state_type     st;
    fsms_state_type     next_st;
    logic               tick;
    logic               use_sync;
    logic [21:0]        interval;
    logic               sample_en;
    logic               take;
    logic               notch_on;
    logic               gate_now;
    logic [11:0]        mapped;
    logic [11:0]        lvl_use;
    logic [15:0]        per_calc;
    logic [39:0]        span;
    logic [3:0]         qe;
    logic signed [19:0] b1;
    logic signed [19:0] a2;
    logic signed [39:0] acc;
    logic signed [19:0] y0;
    logic [11:0]        notch_lvl;
    logic signed [16:0] lp_d;
    logic [15:0]        lp_new;
    logic [19:0]        ton_raw;
    logic signed [19:0] pfc_mod;
    logic [12:0]        ceil_sum;
    logic [15:0]        burst_sw;

    assign burst_sw = 16'(BURST_SW_CYC_P);

    always_comb begin
        next_st = st;
        // Register port
        next_st.ack = 1'b0;
        if (psel && !penable) begin
            next_st.ack = 1'b1;
            next_st.err = 1'b0;
            case (paddr)
                ADDR_CTRL:   next_st.rdata = 32'({st.pfc_en, st.regulate_en});
                ADDR_NOTCH:  next_st.rdata = 32'({st.q_shift, st.notch_blank});
                ADDR_BURST:  next_st.rdata = {st.burst_delay, st.wake_cnt};
                ADDR_RAMP:   next_st.rdata = 32'({st.pfc_gain, st.ramp_step});
                ADDR_PERIOD: next_st.rdata = 32'(st.fast_period);
                ADDR_ONTIME: next_st.rdata = 32'({st.ton_gain, st.ton_min});
                ADDR_STATUS: next_st.rdata = 32'({st.level, 11'h000, st.bst == BST_PULSE,
                                                  feedback_pullup_en, notch_on, st.mode});
                ADDR_MAP:    next_st.rdata = {st.on_time, st.min_period};
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.err   = 1'b1;
                end
            endcase
        end
        if (psel && penable && st.ack && pwrite && !st.err) begin
            case (paddr)
                ADDR_CTRL: begin
                    next_st.regulate_en = pwdata[0];
                    next_st.pfc_en      = pwdata[1];
                end
                ADDR_NOTCH: begin
                    next_st.notch_blank = pwdata[7:0];
                    next_st.q_shift     = pwdata[11:8];
                end
                ADDR_BURST: begin
                    next_st.wake_cnt    = pwdata[15:0];
                    next_st.burst_delay = pwdata[31:16];
                end
                ADDR_RAMP: begin
                    next_st.ramp_step = pwdata[7:0];
                    next_st.pfc_gain  = pwdata[15:8];
                end
                ADDR_PERIOD: next_st.fast_period = pwdata[15:0];
                ADDR_ONTIME: begin
                    next_st.ton_min  = pwdata[15:0];
                    next_st.ton_gain = pwdata[23:16];
                end
                default: next_st.err = st.err;
            endcase
        end

        // Half-cycle timing and sync tracking
        next_st.fix_cnt = (st.fix_cnt >= 22'(FIXED_HALF_CYC_P - 1)) ? 22'h0 : st.fix_cnt + 22'h1;
        tick = line_sync ? half_cycle : (st.fix_cnt >= 22'(FIXED_HALF_CYC_P - 1));
        next_st.per_cnt = (&st.per_cnt) ? st.per_cnt : st.per_cnt + 22'h1;
        if (!line_sync) begin
            next_st.sync_age = 8'h00;
        end else if (half_cycle && !(&st.sync_age)) begin
            next_st.sync_age = st.sync_age + 8'h01;
        end
        if (half_cycle) begin
            next_st.per_cnt = 22'h0;
            if (st.mode != MODE_BURST) begin
                next_st.half_period = st.per_cnt;
                next_st.sync_seen   = line_sync;
            end
        end

        // Sample scheduling
        if (st.mode == MODE_BURST) begin
            use_sync = st.sync_at_burst;  // R06
        end else begin
            use_sync = line_sync && st.sync_seen;
        end
        interval = (use_sync ? st.half_period : 22'(FIXED_HALF_CYC_P)) >> SAMPLES_LOG2;  // R02 R03
        sample_en = st.regulate_en && (st.mode != MODE_BURST || st.bst == BST_PULSE);  // R04 R10
        take = sample_en && st.armed && blank_end;  // R01
        next_st.strobe = take;
        if (take) begin
            next_st.armed = 1'b0;
        end
        if (st.int_cnt >= interval) begin
            next_st.int_cnt = 22'h0;
            next_st.armed   = 1'b1;
        end else begin
            next_st.int_cnt = st.int_cnt + 22'h1;
        end

        // Filters
        notch_on = st.mode != MODE_BURST && line_sync && st.sync_age >= st.notch_blank;  // R07
        qe = (st.q_shift == 4'h0) ? 4'h1 : st.q_shift;
        b1 = NOTCH_C2 - (NOTCH_C2 >>> qe);
        a2 = NOTCH_ONE - ((NOTCH_ONE <<< 1) >>> qe);
        acc = ((40'(signed'({4'h0, feedback_sample, 4'h0})) + 40'(signed'({4'h0, st.x2, 4'h0})))
               <<< NOTCH_FRAC)
            - 40'(NOTCH_C2) * 40'(signed'({4'h0, st.x1, 4'h0}))
            + 40'(b1) * 40'(st.y1) - 40'(a2) * 40'(st.y2);  // R08
        y0 = 20'(acc >>> NOTCH_FRAC);
        if (y0 < 0) begin
            notch_lvl = 12'h000;
        end else if (y0[19:16] != 4'h0) begin
            notch_lvl = 12'hfff;
        end else begin
            notch_lvl = y0[15:4];
        end
        lp_d = signed'({1'b0, feedback_sample, 4'h0}) - signed'({1'b0, st.lp});
        lp_new = st.lp + 16'(lp_d >>> LP_SHIFT);
        if (take) begin
            next_st.x2    = st.x1;
            next_st.x1    = feedback_sample;
            next_st.y2    = st.y1;
            next_st.y1    = y0;
            next_st.lp    = lp_new;
            next_st.level = notch_on ? notch_lvl : lp_new[15:4];  // R09 R10 R20
        end

        // Ceiling ramp
        next_st.reg_prev = st.regulate_en;
        ceil_sum = {1'b0, st.ceiling} + 13'(st.ramp_step);
        if (st.regulate_en && !st.reg_prev) begin
            next_st.ceiling = LVL_ON;  // R12
        end else if (tick && st.ceiling < LVL_REF) begin
            next_st.ceiling = (ceil_sum >= {1'b0, LVL_REF}) ? LVL_REF : ceil_sum[11:0];  // R12
        end
        mapped = (st.level < st.ceiling) ? st.level : st.ceiling;  // R11 R12

        // Level to switching parameters
        span = 40'(burst_sw - st.fast_period) * 40'(mapped - LVL_BURST) * MAP_INV;
        if (mapped <= LVL_BURST) begin
            per_calc = burst_sw;
        end else if (mapped >= LVL_SW) begin
            per_calc = st.fast_period;
        end else begin
            per_calc = burst_sw - 16'(span >> MAP_SHIFT);  // R11
        end
        lvl_use = (st.mode == MODE_BURST) ? st.burst_level : mapped;
        ton_raw = 20'(st.ton_min) + ((20'(lvl_use) * 20'(st.ton_gain)) >> TON_SHIFT);
        pfc_mod = 20'((pfc_term * signed'({1'b0, st.pfc_gain})) >>> PFC_SHIFT);
        if (st.pfc_en && st.mode != MODE_BURST) begin
            ton_raw = ton_raw + pfc_mod;  // R16
        end
        if (ton_raw[19] || ton_raw[15:0] < st.ton_min) begin
            next_st.on_time = st.ton_min;  // R18
        end else if (ton_raw[18:16] != 3'h0) begin
            next_st.on_time = 16'hffff;
        end else begin
            next_st.on_time = ton_raw[15:0];
        end
        next_st.min_period  = (st.mode == MODE_BURST) ? burst_sw : per_calc;
        next_st.pulse_count = PULSE_MIN + 5'(lvl_use[11:8]);

        // Switch turn-on
        gate_now = 1'b0;
        next_st.sw_cnt = (&st.sw_cnt) ? st.sw_cnt : st.sw_cnt + 16'h0001;
        if (valley_pulse) begin
            next_st.valley_seen = 1'b1;
        end
        if (st.regulate_en) begin
            unique case (st.mode)
                MODE_FV:    gate_now = valley_pulse && !st.valley_seen;  // R14
                MODE_DCM:   gate_now = st.valley_seen && st.sw_cnt >= st.min_period;  // R15
                MODE_BURST: gate_now = st.bst == BST_PULSE && st.pulses_left != 5'h00
                                       && st.sw_cnt >= burst_sw;
                default:    gate_now = 1'b0;
            endcase
        end
        next_st.gate = gate_now;
        if (gate_now) begin
            next_st.sw_cnt      = 16'h0000;
            next_st.valley_seen = 1'b0;
        end

        // Mode selection and burst sequencing
        if (!st.regulate_en) begin
            next_st.mode      = MODE_DCM;
            next_st.bst       = BST_SLEEP;
            next_st.below_cnt = 24'h00_0000;
        end else begin
            unique case (st.mode)
                MODE_FV, MODE_DCM: begin
                    if (mapped >= LVL_BURST) begin
                        next_st.below_cnt = 24'h00_0000;
                    end else if (!(&st.below_cnt)) begin
                        next_st.below_cnt = st.below_cnt + 24'h00_0001;
                    end
                    if (mapped < LVL_BURST && st.below_cnt >= {st.burst_delay, 8'h00}) begin
                        next_st.mode          = MODE_BURST;  // R17
                        next_st.bst           = BST_SLEEP;
                        next_st.sync_at_burst = line_sync && st.sync_seen;
                        next_st.burst_level   = mapped;
                    end else if (mapped >= LVL_ON && per_calc < first_valley_period) begin
                        next_st.mode = MODE_FV;  // R13
                    end else begin
                        next_st.mode = MODE_DCM;  // R18 R19
                    end
                end
                MODE_BURST: begin
                    unique case (st.bst)
                        BST_SLEEP: begin
                            if (burst_tick) begin
                                next_st.bst     = BST_WAKE;
                                next_st.bst_cnt = st.wake_cnt;
                            end
                        end
                        BST_WAKE: begin
                            if (st.bst_cnt == 16'h0000) begin
                                next_st.bst         = BST_PULSE;  // R05
                                next_st.pulses_left = st.pulse_count;
                                next_st.sw_cnt      = burst_sw;
                            end else begin
                                next_st.bst_cnt = st.bst_cnt - 16'h0001;
                            end
                        end
                        BST_PULSE: begin
                            // Last period runs out first, so its sample lands
                            if (gate_now) begin
                                next_st.pulses_left = st.pulses_left - 5'h01;
                            end else if (st.pulses_left == 5'h00 && st.sw_cnt >= burst_sw) begin
                                next_st.bst         = BST_SLEEP;
                                next_st.burst_level = mapped;
                                if (mapped > LVL_BURST) begin
                                    next_st.mode      = MODE_DCM;
                                    next_st.below_cnt = 24'h00_0000;
                                end
                            end
                        end
                        default: next_st.bst = BST_SLEEP;
                    endcase
                end
                default: next_st.mode = MODE_DCM;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata                  = st.rdata;
    assign pready                  = psel && penable && st.ack;
    assign pslverr                 = psel && penable && st.ack && st.err;
    assign sample_strobe           = st.strobe;
    assign feedback_pullup_en      = !(st.mode == MODE_BURST && st.bst == BST_SLEEP);  // R04
    assign gate_drive_on           = st.gate;
    assign operating_mode          = st.mode;
    assign on_time                 = st.on_time;
    assign min_period              = st.min_period;
    assign pulse_count             = st.pulse_count;
    assign filtered_feedback_level = st.level;
    assign feedback_ceiling        = st.ceiling;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wake_end;
        st.bst == BST_WAKE ##1 st.bst == BST_PULSE;
    endsequence
    sequence s_sleeping;
        (st.mode == MODE_BURST && st.bst == BST_SLEEP) [*2];
    endsequence

    chk_sample_blank: assert property (sample_strobe |-> $past(blank_end))  // R01
        else $error("sample not right after blanking");
    chk_sleep_quiet: assert property ((st.mode == MODE_BURST && st.bst != BST_PULSE)
        |=> !sample_strobe)  // R04
        else $error("sample taken outside burst pulsing");
    chk_pullup_lead: assert property (s_wake_end |-> feedback_pullup_en
        && $past(st.bst_cnt) == 16'h0000)  // R05
        else $error("pull-up not on before pulsing");
    chk_burst_lowpass: assert property (st.mode == MODE_BURST && take  // R10
        |=> filtered_feedback_level == $past(lp_new[15:4]))
        else $error("notch active in burst");
    chk_hold_level: assert property (s_sleeping |-> $stable(filtered_feedback_level))  // R20
        else $error("level moved in burst sleep");
    chk_ceiling_start: assert property (st.regulate_en && !st.reg_prev
        |=> feedback_ceiling == LVL_ON)  // R12
        else $error("ceiling ramp did not restart");
    chk_fv_level: assert property (operating_mode == MODE_FV && $past(st.regulate_en)
        |-> $past(mapped) >= LVL_ON)  // R13
        else $error("first-valley mode below threshold");
    chk_burst_entry: assert property ($rose(st.mode == MODE_BURST)
        |-> $past(mapped) < LVL_BURST)  // R17
        else $error("burst entered above threshold");
    chk_fv_first: assert property (gate_drive_on && $past(st.mode) == MODE_FV
        |-> $past(valley_pulse) && !$past(st.valley_seen))  // R14
        else $error("first-valley turn-on not at first valley");
    chk_dcm_late: assert property (gate_drive_on && $past(st.mode) == MODE_DCM
        |-> $past(st.valley_seen) && $past(st.sw_cnt) >= $past(st.min_period))  // R15
        else $error("discontinuous turn-on too early");
endmodule : fsms_core
`default_nettype wire

/* fsms_plant.sv */
// Far side: feedback network and flyback stage.
// Assumes one-cycle gate pulses; the bench sets the feedback level.
`timescale 1ns/100ps
`default_nettype none
module fsms_plant (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        gate_drive_on,
    input  wire logic        feedback_pullup_en,
    input  wire logic [11:0] fb_target,
    output logic      [11:0] feedback_sample,
    output logic             blank_end,
    output logic             valley_pulse
);
    logic [8:0] t;
    // Pull-up off: optocoupler drags the pin low
    assign feedback_sample = feedback_pullup_en ? fb_target : 12'h000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t <= 9'h000;
        end else begin
            // Saturates, so blanking ends only after a turn-on
            t <= gate_drive_on ? 9'h101 : (&t[7:0]) ? t : t + 9'h001;
        end
    end
    assign blank_end    = (t == 9'h103);
    // Aux ringing gives a valley every 16 cycles
    assign valley_pulse = (t[3:0] == 4'h0) && (t[7:4] != 4'h0);
endmodule : fsms_plant
`default_nettype wire

/* tb.sv */
// Self-checking bench: registers, burst entry, wake-up, recovery.
// Assumes fsms_plant on the far side and shortened period counts.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fsms_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, burst_tick, err;
    logic        blank_end, valley_pulse, sample_strobe, feedback_pullup_en, gate_drive_on;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] feedback_sample, filtered_feedback_level, feedback_ceiling, fb_target, hold;
    logic [1:0]  operating_mode;
    logic [15:0] on_time, min_period, fv_per;
    logic [4:0]  pulse_count;
    logic        be_q;
    int          fails, cmp_count, gap, n;
    fsms_core #(.FIXED_HALF_CYC_P(640), .BURST_SW_CYC_P(100)) uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .feedback_sample, .blank_end, .line_sync(1'b0), .half_cycle(1'b0), .valley_pulse,
        .first_valley_period(fv_per), .burst_tick, .pfc_term(12'sh000), .sample_strobe,
        .feedback_pullup_en, .gate_drive_on, .operating_mode, .on_time, .min_period,
        .pulse_count, .filtered_feedback_level, .feedback_ceiling);
    fsms_plant plant (.pclk, .presetn, .gate_drive_on, .feedback_pullup_en, .fb_target,
        .feedback_sample, .blank_end, .valley_pulse);
    task automatic close_out();
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bound(input int lim);
        if (n >= lim) begin
            fails++;
            close_out();
        end
    endtask : bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        bound(50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic tick();
        @(posedge pclk);
        burst_tick <= 1'b1;
        @(posedge pclk);
        burst_tick <= 1'b0;
    endtask : tick
    task automatic regs_test();
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            check("reset value", rd, 32'h0);
        end
        apb(1'b1, ADDR_BURST, 32'h0001_0010);
        apb(1'b1, ADDR_RAMP, 32'h0000_00ff);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl readback", rd, 32'h0000_0001);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", err, 1'b1);
    endtask : regs_test
    task automatic burst_test();
        fb_target <= 12'h1f4;
        for (n = 0; n < 4000 && operating_mode !== MODE_BURST; n++) @(negedge pclk);
        bound(4000);
        check("burst entry", operating_mode, MODE_BURST);
        hold = filtered_feedback_level;
        repeat (300) @(negedge pclk);
        check("pull-up asleep", feedback_pullup_en, 1'b0);
        check("level held", filtered_feedback_level, hold);
        tick();
        for (n = 0; n < 200 && gate_drive_on !== 1'b1; n++) @(negedge pclk);
        bound(200);
        check("wake lead", n >= 16, 1'b1);
        check("pull-up at pulse", feedback_pullup_en, 1'b1);
    endtask : burst_test
    task automatic dcm_test();
        fb_target <= 12'h3e8;
        for (n = 0; n < 60 && operating_mode !== MODE_DCM; n++) begin
            tick();
            repeat (1500) @(negedge pclk);
        end
        bound(60);
        check("burst exit", operating_mode, MODE_DCM);
        check("level band", filtered_feedback_level > LVL_BURST, 1'b1);
    endtask : dcm_test
    // Every sample follows blanking, keeps its spacing and has the pull-up on
    always @(negedge pclk) begin
        if (sample_strobe === 1'b1) begin
            check("after blanking", be_q, 1'b1);
            check("spacing", gap >= 11, 1'b1);
            check("pull-up sampling", feedback_pullup_en, 1'b1);
            gap = 0;
        end
        be_q = blank_end;
        gap++;
    end
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, burst_tick} = '0;
        fb_target = 12'h000;
        fv_per    = 16'h0100;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        regs_test();
        burst_test();
        dcm_test();
        close_out();
    end
endmodule : tb
`default_nettype wire
